// ==== hdl/radio_shortcut_irq_enable.sv ====
// radio event-to-task shortcut links, interrupt enable bank and event flags
// Overview of operation
// RQ1: rx_ramped triggers channel_check_begin when its link bit is one.
// RQ2: medium_clear triggers transmit_ramp_up when its link bit is one.
// RQ3: medium_occupied triggers radio disable when its link bit is one.
// RQ4: frame_length_seen triggers bit_count_begin when its link bit is one.
// RQ5: ready event triggers energy_scan_begin when its link bit is one.
// RQ6: energy_scan_done triggers radio disable when its link bit is one.
// RQ7: medium_clear triggers radio stop, independent of its ramp-up link.
// RQ8: tx_ramped triggers radio start when its link bit is one.
// RQ9: rx_ramped triggers radio start, independent of its channel-check link.
// RQ10: last_bit_on_air triggers radio disable when its link bit is one.
// RQ11: last_bit_on_air triggers radio start, separate from its disable link.
// RQ12: writing one at set register enables interrupt; reads show enable state.
// RQ13: each radio event owns its own interrupt enable bit.
// RQ14: writing one at clear register disables interrupt; reads show same state.
// RQ15: preamble_hint may be false; it only sets a flag, nothing more.
// RQ16: signal_strength_done raised only when a fresh sample is latched.
// RQ17: bit_count_hit raised when received bit count reaches compare value.
// RQ18: medium_clear means channel idle; medium_occupied means channel busy.
// RQ19: last_bit_on_air raised when final frame bit sent or received.
// RQ20: writing zero to set or clear bits leaves enables unchanged.
// RQ21: interrupt output high while any flag and its enable are set.
//
// Design decision made here: the APB slave port.
module radio_shortcut_irq_enable #(
    parameter int bit_cnt_width = 16,
    parameter int rssi_width    = 7
) (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic [31:0]              radio_events,
    input  wire logic                     rssi_valid,
    input  wire logic [rssi_width-1:0]    rssi_value,
    input  wire logic [bit_cnt_width-1:0] rx_bit_count,
    input  wire logic                     rx_bit_count_run,
    output radio_link_pkg::task_pulse_t   task_pulses,
    output logic      [rssi_width-1:0]    signal_strength_sample,
    output logic                          irq
);

    // refuse widths the compare register cannot hold
    initial
    begin
        if (bit_cnt_width < 1 || bit_cnt_width > 32 || rssi_width < 1 || rssi_width > 32)
            $error("radio_shortcut_irq_enable: unsupported width parameter");
    end

    logic [31:0]              link_ff;
    logic [31:0]              irq_en_ff;
    logic [31:0]              flag_ff;
    logic [31:0]              bc_cmp_ff;
    logic [rssi_width-1:0]    rssi_ff;
    logic                     bc_armed_ff;
    radio_link_pkg::task_pulse_t task_ff;
    logic [31:0]              prdata_ff;
    logic                     pready_ff;
    logic                     pslverr_ff;
    logic                     irq_ff;

    radio_link_pkg::apb_req_t req;
    radio_link_pkg::task_pulse_t nxt_task;
    logic [31:0]              nxt_link;
    logic [31:0]              nxt_irq_en;
    logic [31:0]              nxt_flag;
    logic [31:0]              nxt_bc_cmp;
    logic [31:0]              nxt_prdata;
    logic [31:0]              ev;
    logic [31:0]              hw_set;
    logic [31:0]              sw_clr;
    logic                     nxt_irq;
    logic                     bc_hit;
    logic                     nxt_bc_armed;

    // bus request bundle
    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

    // address decode; one-wait-state slave, answers in the cycle after the first access cycle
    wire acc      = req.psel && req.penable && !pready_ff;
    wire wr       = acc && req.pwrite;
    wire rd       = acc && !req.pwrite;
    wire hit_link = req.paddr == radio_link_pkg::link_reg_off;
    wire hit_set  = req.paddr == radio_link_pkg::irq_set_reg_off;
    wire hit_clr  = req.paddr == radio_link_pkg::irq_clr_reg_off;
    wire hit_flag = req.paddr == radio_link_pkg::evt_flag_reg_off;
    wire hit_bc   = req.paddr == radio_link_pkg::bc_cmp_reg_off;
    wire hit_any  = hit_link | hit_set | hit_clr | hit_flag | hit_bc;

    // bit counter compare match, once per armed run
    assign bc_hit = rx_bit_count_run && bc_armed_ff
                    && ({{(32 - bit_cnt_width){1'b0}}, rx_bit_count} == bc_cmp_ff); // RQ17
    assign nxt_bc_armed = !rx_bit_count_run ? 1'b1 : (bc_hit ? 1'b0 : bc_armed_ff);

    // incoming events; internally made ones overlay their slots
    always_comb
    begin
        ev = radio_events & radio_link_pkg::event_mask; // RQ18 RQ19
        ev[radio_link_pkg::ev_bc_hit]    = bc_hit; // RQ17
        ev[radio_link_pkg::ev_rssi_done] = rssi_valid; // RQ16
    end

    // flags: hardware set wins over software clear
    assign hw_set   = ev; // RQ15
    assign sw_clr   = (wr && hit_flag) ? req.pwdata : 32'h0000_0000;
    assign nxt_flag = ((flag_ff & ~sw_clr) | hw_set) & radio_link_pkg::event_mask;

    // enable bank, write-one-to-set and write-one-to-clear
    assign nxt_irq_en = ((wr && hit_set) ? (irq_en_ff | (req.pwdata & radio_link_pkg::event_mask)) // RQ12 RQ13 RQ20
                       : (wr && hit_clr) ? (irq_en_ff & ~req.pwdata) // RQ14 RQ20
                       : irq_en_ff);
    assign nxt_link   = (wr && hit_link) ? (req.pwdata & radio_link_pkg::link_mask) : link_ff;
    assign nxt_bc_cmp = (wr && hit_bc) ? req.pwdata : bc_cmp_ff;
    assign nxt_irq    = |(nxt_flag & nxt_irq_en); // RQ21

    // read mux; set and clear share one view of the enables
    assign nxt_prdata = !rd ? prdata_ff
                      : (hit_set || hit_clr) ? irq_en_ff // RQ12 RQ14
                      : hit_link ? link_ff
                      : hit_flag ? flag_ff
                      : hit_bc ? bc_cmp_ff
                      : 32'h0000_0000;

    // shortcut links: each link bit gates one event onto one task
    always_comb
    begin
        nxt_task.channel_check_begin = link_ff[radio_link_pkg::lk_rx_ramped_check]
                                       && ev[radio_link_pkg::ev_rx_ramped]; // RQ1
        nxt_task.transmit_ramp_up    = link_ff[radio_link_pkg::lk_clear_txramp]
                                       && ev[radio_link_pkg::ev_medium_clear]; // RQ2
        nxt_task.disable_radio       = (link_ff[radio_link_pkg::lk_occupied_disable]
                                        && ev[radio_link_pkg::ev_medium_busy]) // RQ3
                                     | (link_ff[radio_link_pkg::lk_escan_disable]
                                        && ev[radio_link_pkg::ev_escan_done]) // RQ6
                                     | (link_ff[radio_link_pkg::lk_phy_disable]
                                        && ev[radio_link_pkg::ev_last_bit]); // RQ10
        nxt_task.bit_count_begin     = link_ff[radio_link_pkg::lk_frame_bitcount]
                                       && ev[radio_link_pkg::ev_frame_seen]; // RQ4
        nxt_task.energy_scan_begin   = link_ff[radio_link_pkg::lk_ready_escan]
                                       && ev[radio_link_pkg::ev_ready]; // RQ5
        nxt_task.stop_radio          = link_ff[radio_link_pkg::lk_clear_stop]
                                       && ev[radio_link_pkg::ev_medium_clear]; // RQ7
        nxt_task.start_radio         = (link_ff[radio_link_pkg::lk_tx_ramped_start]
                                        && ev[radio_link_pkg::ev_tx_ramped]) // RQ8
                                     | (link_ff[radio_link_pkg::lk_rx_ramped_start]
                                        && ev[radio_link_pkg::ev_rx_ramped]) // RQ9
                                     | (link_ff[radio_link_pkg::lk_phy_start]
                                        && ev[radio_link_pkg::ev_last_bit]); // RQ11
    end

    // register state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            link_ff     <= radio_link_pkg::link_reset;
            irq_en_ff   <= radio_link_pkg::irq_en_reset;
            flag_ff     <= 32'h0000_0000;
            bc_cmp_ff   <= radio_link_pkg::bc_cmp_reset;
            bc_armed_ff <= 1'b1;
        end
        else
        begin
            link_ff     <= nxt_link;
            irq_en_ff   <= nxt_irq_en;
            flag_ff     <= nxt_flag;
            bc_cmp_ff   <= nxt_bc_cmp;
            bc_armed_ff <= nxt_bc_armed;
        end
    end

    // fresh signal strength sample latched with its done event
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rssi_ff <= '0;
        else if (rssi_valid)
            rssi_ff <= rssi_value; // RQ16
    end

    // registered outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            task_ff    <= '0;
            prdata_ff  <= 32'h0000_0000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            irq_ff     <= 1'b0;
        end
        else
        begin
            task_ff    <= nxt_task;
            prdata_ff  <= nxt_prdata;
            pready_ff  <= acc;
            pslverr_ff <= acc && !hit_any;
            irq_ff     <= nxt_irq;
        end
    end

    assign task_pulses            = task_ff;
    assign prdata                 = prdata_ff;
    assign pready                 = pready_ff;
    assign pslverr                = pslverr_ff;
    assign irq                    = irq_ff;
    assign signal_strength_sample = rssi_ff;

endmodule

// ==== include/radio_link_pkg.sv ====
// package: register map, field positions and bus carriers for the radio link/irq block
package radio_link_pkg;

    // register byte offsets
    localparam logic [11:0] link_reg_off     = 12'h200;
    localparam logic [11:0] irq_set_reg_off  = 12'h304;
    localparam logic [11:0] irq_clr_reg_off  = 12'h308;
    localparam logic [11:0] evt_flag_reg_off = 12'h310;
    localparam logic [11:0] bc_cmp_reg_off   = 12'h320;

    // reset values
    localparam logic [31:0] link_reset    = 32'h0000_0000;
    localparam logic [31:0] irq_en_reset  = 32'h0000_0000;
    localparam logic [31:0] bc_cmp_reset  = 32'h0000_0000;

    // shortcut bit positions in the link register
    localparam int lk_rx_ramped_check  = 11;
    localparam int lk_clear_txramp     = 12;
    localparam int lk_occupied_disable = 13;
    localparam int lk_frame_bitcount   = 14;
    localparam int lk_ready_escan      = 15;
    localparam int lk_escan_disable    = 16;
    localparam int lk_clear_stop       = 17;
    localparam int lk_tx_ramped_start  = 18;
    localparam int lk_rx_ramped_start  = 19;
    localparam int lk_phy_disable      = 20;
    localparam int lk_phy_start        = 21;
    localparam logic [31:0] link_mask  = 32'h003f_f800;

    // event bit positions, shared by enable and flag registers
    localparam int ev_ready        = 0;
    localparam int ev_rssi_done    = 7;
    localparam int ev_bc_hit       = 8;
    localparam int ev_frame_seen   = 12;
    localparam int ev_escan_done   = 13;
    localparam int ev_medium_clear = 15;
    localparam int ev_medium_busy  = 16;
    localparam int ev_tx_ramped    = 19;
    localparam int ev_rx_ramped    = 20;
    localparam int ev_preamble     = 23;
    localparam int ev_last_bit     = 24;
    localparam logic [31:0] event_mask = 32'h03bf_f5ff;

    // apb request carrier
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    // task trigger carrier
    typedef struct packed {
        logic channel_check_begin;
        logic transmit_ramp_up;
        logic disable_radio;
        logic bit_count_begin;
        logic energy_scan_begin;
        logic stop_radio;
        logic start_radio;
    } task_pulse_t;

endpackage

// ==== test/radio_shortcut_irq_enable_asserts.sv ====
// checker: shortcut pulse causes and bus answer timing
module radio_shortcut_irq_enable_asserts (
    input wire logic                        pclk,
    input wire logic                        presetn,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pready,
    input wire logic                        pslverr,
    input wire logic [31:0]                 radio_events,
    input wire radio_link_pkg::task_pulse_t task_pulses
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // every task pulse needs its source event one cycle before
    property p_chk; task_pulses.channel_check_begin |-> $past(radio_events[20]); endproperty
    a_chk: assert property (p_chk) else $error("check pulse without rx ramp");
    property p_txr; task_pulses.transmit_ramp_up |-> $past(radio_events[15]); endproperty
    a_txr: assert property (p_txr) else $error("ramp pulse without clear");
    property p_dis; task_pulses.disable_radio |-> $past(radio_events[16] | radio_events[13] | radio_events[24]); endproperty
    a_dis: assert property (p_dis) else $error("disable pulse without cause");
    property p_bcb; task_pulses.bit_count_begin |-> $past(radio_events[12]); endproperty
    a_bcb: assert property (p_bcb) else $error("bit count pulse without frame");
    property p_esc; task_pulses.energy_scan_begin |-> $past(radio_events[0]); endproperty
    a_esc: assert property (p_esc) else $error("scan pulse without ready");
    property p_stp; task_pulses.stop_radio |-> $past(radio_events[15]); endproperty
    a_stp: assert property (p_stp) else $error("stop pulse without clear");
    property p_sta; task_pulses.start_radio |-> $past(radio_events[19] | radio_events[20] | radio_events[24]); endproperty
    a_sta: assert property (p_sta) else $error("start pulse without cause");
    // bus answer: one wait state, one-cycle ready, error only with ready
    property p_wt; psel && $rose(penable) |-> ##1 pready; endproperty
    a_wt: assert property (p_wt) else $error("ready not after one wait state");
    property p_rdy; pready |=> !pready; endproperty
    a_rdy: assert property (p_rdy) else $error("ready longer than one cycle");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    c_two: cover property (task_pulses.stop_radio && task_pulses.transmit_ramp_up);
    c_err: cover property (pslverr);
    c_dis: cover property (task_pulses.disable_radio && task_pulses.start_radio);
endmodule

bind radio_shortcut_irq_enable radio_shortcut_irq_enable_asserts u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .radio_events(radio_events),
    .task_pulses(task_pulses));

// ==== test/test_radio_shortcut_irq_enable.sv ====
// testbench: register access, shortcut links, irq enables
module test_radio_shortcut_irq_enable;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] sa = radio_link_pkg::irq_set_reg_off;
    localparam logic [11:0] ca = radio_link_pkg::irq_clr_reg_off;
    localparam logic [11:0] la = radio_link_pkg::link_reg_off;
    localparam logic [11:0] fa = radio_link_pkg::evt_flag_reg_off;
    localparam int lev[11] = '{20, 15, 16, 12, 0, 13, 15, 19, 20, 24, 24};
    localparam int ltk[11] = '{6, 5, 4, 3, 2, 4, 1, 0, 0, 4, 0};
    localparam int evs[8] = '{0, 12, 13, 15, 16, 19, 20, 24};
    logic                        pclk, presetn, psel, penable, pwrite, pready, pslverr, rssi_valid, run, irq;
    logic [11:0]                 paddr;
    logic [31:0]                 pwdata, prdata, radio_events, link, en, r;
    logic [15:0]                 rx_bit_count, seed;
    logic [6:0]                  rssi_value, sample;
    radio_link_pkg::task_pulse_t task_pulses;
    logic [32:0]                 rd_q[$];
    logic [6:0]                  tk_q[$];
    int                          failures, total_checks;

    radio_shortcut_irq_enable dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .radio_events(radio_events), .rssi_valid(rssi_valid), .rssi_value(rssi_value),
        .rx_bit_count(rx_bit_count), .rx_bit_count_run(run), .task_pulses(task_pulses),
        .signal_strength_sample(sample), .irq(irq));

    // clock
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one apb transfer, held until ready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        rd_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    // one event cycle, expected pulses from the link table
    task automatic fire(input logic [31:0] ev);
        logic [6:0] e;
        e = 7'h0;
        for (int k = 0; k < 11; k++)
            if (link[11 + k] && ev[lev[k]])
                e[ltk[k]] = 1'b1;
        @(posedge pclk);
        radio_events <= ev;
        @(posedge pclk);
        radio_events <= 32'h0;
        tk_q.push_back(e);
    endtask

    task automatic rnd();
        r = {seed, seed ^ 16'h5a5a};
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    endtask

    task automatic print_verdict();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // result monitor
    always @(negedge pclk)
    begin
        if (pready === 1'b1 && pwrite === 1'b0 && rd_q.size() > 0)
            check("prdata", {pslverr, prdata}, rd_q.pop_front());
        if (tk_q.size() > 0)
            check("task_pulses", 33'(task_pulses), 33'(tk_q.pop_front()));
    end

    initial
    begin
        repeat (5000) @(posedge pclk);
        failures++;
        print_verdict();
    end

    initial
    begin
        {presetn, psel, penable, pwrite, rssi_valid, run} = 6'h0;
        {paddr, pwdata, radio_events, rssi_value, rx_bit_count} = '0;
        {link, en, seed, failures, total_checks} = {64'h0, 16'hd6b6, 64'h0};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(sa, 33'h0);
        rd(ca, 33'h0);
        rd(la, 33'h0);
        rd(12'h100, 33'h1_0000_0000);
        $display("test reset done");
        repeat (8)
        begin
            rnd();
            apb(1'b1, sa, r);
            en = (en | r) & radio_link_pkg::event_mask;
            apb(1'b1, sa, 32'h0);
            rd(sa, {1'b0, en});
            rnd();
            apb(1'b1, ca, r);
            en = en & ~r;
            apb(1'b1, ca, 32'h0);
            rd(ca, {1'b0, en});
        end
        $display("test enables done");
        rnd();
        apb(1'b1, la, r);
        rd(la, {1'b0, r & radio_link_pkg::link_mask});
        for (int k = 0; k < 12; k++)
        begin
            link = (k < 11) ? (32'h1 << (11 + k)) : radio_link_pkg::link_mask;
            apb(1'b1, la, link);
            rd(la, {1'b0, link});
            foreach (evs[i])
                fire(32'h1 << evs[i]);
            rnd();
            fire(r & 32'h0119_b001);
        end
        $display("test links done");
        apb(1'b1, ca, 32'hffff_ffff);
        apb(1'b1, fa, 32'hffff_ffff);
        apb(1'b1, sa, 32'h0008_0100);
        check("irq", irq, 0);
        fire(32'h0008_0000);
        #1 check("irq", irq, 1);
        apb(1'b1, ca, 32'h0008_0000);
        #1 check("irq", irq, 0);
        apb(1'b1, radio_link_pkg::bc_cmp_reg_off, 32'h5);
        rx_bit_count <= 16'h5;
        run <= 1'b1;
        repeat (3) @(posedge pclk);
        check("irq", irq, 1);
        rd(fa, 33'h8_0100);
        rssi_value <= 7'h2a;
        rssi_valid <= 1'b1;
        @(posedge pclk);
        rssi_valid <= 1'b0;
        @(posedge pclk);
        check("sample", sample, 7'h2a);
        rd(fa, 33'h8_0180);
        $display("test irq done");
        print_verdict();
    end
endmodule
